//--- logic/port_regs_pkg.sv
// Package for the per-port receive status and control register block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
`default_nettype none
package port_regs_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] OFF_RX_EVENT_STATUS = 8'h00;
  localparam logic [7:0] OFF_PORT_CONTROL = 8'h04;
  localparam logic [7:0] OFF_DEVICE_IDENTIFIER = 8'h08;
  localparam logic [7:0] OFF_REVISION_IDENTIFIER = 8'h0C;
  localparam logic [7:0] OFF_RX_FILTERING_MODE = 8'h10;
  localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h14;
  // ==========================================================================
  // Receive event bit positions
  localparam int BIT_PAUSE_FRAME_SEEN = 7;
  localparam int BIT_MEDIA_ERROR = 5;
  localparam int BIT_OVERSIZE_FRAME = 4;
  localparam int BIT_UNDERSIZE_FRAME = 3;
  localparam int BIT_ALIGNMENT_ERROR = 2;
  localparam int BIT_FCS_ERROR = 1;
  localparam int BIT_RX_FIFO_OVERRUN = 0;
  localparam logic [7:0] RX_EVENT_VALID_MASK = 8'hBF;
  // ==========================================================================
  // Port control bit positions
  localparam int BIT_TX_RESTART = 5;
  localparam int BIT_TX_ENABLE = 4;
  localparam int BIT_RX_ENABLE = 3;
  localparam int BIT_DATAPATH_RESET = 2;
  localparam int BIT_REGISTER_RESET = 1;
  localparam int BIT_STATISTICS_RESET = 0;
  localparam logic [7:0] PORT_CONTROL_MASK = 8'h3F;
  localparam int BIT_STOPPED = 6;
  // ==========================================================================
  // Reset values and identity (identity values are arbitrary)
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] DEVICE_IDENTIFIER_VALUE = 8'hA5;
  localparam logic [3:0] MAIN_REVISION_VALUE = 4'h2;
  localparam logic [3:0] SUB_REVISION_VALUE = 4'h3;
  localparam logic [7:0] MIN_FRAME_BYTES = 8'h40;
  // ==========================================================================
  // Timing: counter clear takes 100 cycles
  localparam int STATS_CLEAR_CYCLES = 100;
  localparam logic [6:0] STATS_CLEAR_LAST = 7'(STATS_CLEAR_CYCLES - 1);
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PATH_RUN = 2'b00,
    PATH_DRAIN = 2'b01,
    PATH_STOP = 2'b11
  } path_state_e;
  // End-of-frame report from the receive datapath
  typedef struct packed {
    logic done;
    logic pause_frame;
    logic media_error;
    logic oversize;
    logic [15:0] length;
    logic fcs_error;
    logic framing_error;
    logic fifo_overrun;
  } rx_frame_s;
  // Byte into the receive FIFO
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } fifo_byte_s;
endpackage : port_regs_pkg
`default_nettype wire

//--- logic/port_regs.sv
// Per-port receive event status, port control and identity registers.
// Assumes an APB master on clock_i and a datapath on the same clock.
// How it works
// - Reading receive event status clears its bits, except those of a frame ending in that cycle.
// - A status bit sets only if filtering mode passes that event.
// - Multi-error frame passed with missing filter bits sets no status bits.
// - Status byte is written to the receive FIFO after the frame's last byte.
// - Bit 7 marks a pause frame; bit 6 is reserved.
// - Bit 5 marks a symbol or media receive error.
// - Bit 4 marks a frame over the maximum length.
// - Bit 3 marks a frame shorter than 64 bytes.
// - Bit 2 marks frame check plus framing error.
// - Bit 1 marks frame check error without framing error.
// - Bit 0 marks receive FIFO overrun during the frame.
// - Writing one to control bit 5 pulses a transmit restart.
// - Clearing bit 4 drains the transmit frame, stops, flags stopped.
// - Clearing bit 3 drains the receive frame, stops, flags stopped.
// - Control bit 2 resets transmit and receive logic.
// - Register reset restores all but port control and resets datapath.
// - Counter reset clears statistics, lasting 100 cycles.
// - Read-only device identifier in bits 7:0, port 0 only.
// - Revision register: main 7:4, sub 3:0, port 0 only.
// - Stopped flag sets when disabled paths have all stopped.
`default_nettype none
module port_regs #(
  parameter bit IS_PORT_ZERO = 1'b1
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire port_regs_pkg::rx_frame_s rx_frame_i,
  input wire port_regs_pkg::fifo_byte_s rx_data_i,
  input wire logic symbol_mode_i,
  input wire logic tx_busy_i,
  input wire logic rx_busy_i,
  output port_regs_pkg::fifo_byte_s fifo_write_o,
  output logic tx_enable_o,
  output logic rx_enable_o,
  output logic tx_restart_o,
  output logic datapath_reset_o,
  output logic statistics_clear_o,
  output logic [7:0] rx_filtering_mode_o,
  output logic [7:0] rx_event_status_o,
  output logic stopped_o
);
  // ==========================================================================
  // Bus decode
  logic access;
  logic wr;
  logic rd;
  logic lane0;
  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i;
  assign rd = access && !pwrite_i;
  assign lane0 = pstrb_i[0];

  logic [7:0] port_control_reg;
  logic [7:0] rx_filtering_mode_reg;
  logic [7:0] rx_event_status_reg;
  logic stopped_reg;
  logic register_reset_reg;
  logic datapath_reset_reg;
  logic [6:0] stats_count_reg;
  logic stats_busy_reg;
  port_regs_pkg::path_state_e tx_state_reg;
  port_regs_pkg::path_state_e rx_state_reg;
  logic pending_reg;
  logic [7:0] pending_byte_reg;
  port_regs_pkg::fifo_byte_s fifo_write_reg;
  logic soft_reset;
  assign soft_reset = register_reset_reg;

  // Port control: reserved bits stay zero; trigger and reset bits self-clear
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      port_control_reg <= port_regs_pkg::RESET_BYTE;
    end
    else if (wr && lane0 && paddr_i == port_regs_pkg::OFF_PORT_CONTROL)
    begin
      port_control_reg <= pwdata_i[7:0] & port_regs_pkg::PORT_CONTROL_MASK;
    end
    else
    begin
      port_control_reg[port_regs_pkg::BIT_TX_RESTART] <= 1'b0;
      port_control_reg[port_regs_pkg::BIT_DATAPATH_RESET] <= 1'b0;
      port_control_reg[port_regs_pkg::BIT_REGISTER_RESET] <= 1'b0;
      if (stats_busy_reg && stats_count_reg == port_regs_pkg::STATS_CLEAR_LAST)
      begin
        port_control_reg[port_regs_pkg::BIT_STATISTICS_RESET] <= 1'b0;
      end
    end
  end

  // Register reset pulse, one cycle after the write lands
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      register_reset_reg <= 1'b0;
      datapath_reset_reg <= 1'b0;
    end
    else
    begin
      register_reset_reg <= port_control_reg[port_regs_pkg::BIT_REGISTER_RESET];
      datapath_reset_reg <= port_control_reg[port_regs_pkg::BIT_DATAPATH_RESET]
                            || port_control_reg[port_regs_pkg::BIT_REGISTER_RESET];
    end
  end

  // Statistics clear sequencer, 100 cycles long
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      stats_busy_reg <= 1'b0;
      stats_count_reg <= 7'h00;
    end
    else if (stats_busy_reg)
    begin
      if (stats_count_reg == port_regs_pkg::STATS_CLEAR_LAST)
      begin
        stats_busy_reg <= 1'b0;
        stats_count_reg <= 7'h00;
      end
      else
      begin
        stats_count_reg <= stats_count_reg + 7'h01;
      end
    end
    else if (port_control_reg[port_regs_pkg::BIT_STATISTICS_RESET])
    begin
      stats_busy_reg <= 1'b1; // relies on host not mixing with
    end
  end

  // Receive filtering mode, restored by register reset
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || soft_reset)
    begin
      rx_filtering_mode_reg <= port_regs_pkg::RESET_BYTE;
    end
    else if (wr && lane0 && paddr_i == port_regs_pkg::OFF_RX_FILTERING_MODE)
    begin
      rx_filtering_mode_reg <= pwdata_i[7:0] & port_regs_pkg::RX_EVENT_VALID_MASK;
    end
  end

  // ==========================================================================
  // Frame event classification
  logic [7:0] raw_events;
  logic [7:0] passed_events;
  logic frame_events_ok;
  always_comb
  begin
    raw_events = 8'h00;
    raw_events[port_regs_pkg::BIT_PAUSE_FRAME_SEEN] = rx_frame_i.pause_frame;
    raw_events[port_regs_pkg::BIT_MEDIA_ERROR] = rx_frame_i.media_error;
    raw_events[port_regs_pkg::BIT_OVERSIZE_FRAME] = rx_frame_i.oversize;
    raw_events[port_regs_pkg::BIT_UNDERSIZE_FRAME] =
      rx_frame_i.length < {8'h00, port_regs_pkg::MIN_FRAME_BYTES};
    raw_events[port_regs_pkg::BIT_ALIGNMENT_ERROR] =
      rx_frame_i.fcs_error && rx_frame_i.framing_error;
    raw_events[port_regs_pkg::BIT_FCS_ERROR] =
      rx_frame_i.fcs_error && !rx_frame_i.framing_error;
    raw_events[port_regs_pkg::BIT_RX_FIFO_OVERRUN] = rx_frame_i.fifo_overrun;
    // Every event of the frame must be passed by the filter, or none is reported
    frame_events_ok = (raw_events & ~rx_filtering_mode_reg) == 8'h00;
    passed_events = frame_events_ok ? raw_events : 8'h00;
  end

  // Sticky status; a new frame's bits win over a clearing read
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || soft_reset)
    begin
      rx_event_status_reg <= port_regs_pkg::RESET_BYTE;
    end
    else
    begin
      if (rd && paddr_i == port_regs_pkg::OFF_RX_EVENT_STATUS)
      begin
        rx_event_status_reg <= rx_frame_i.done ? passed_events : 8'h00;
      end
      else if (rx_frame_i.done)
      begin
        rx_event_status_reg <= rx_event_status_reg | passed_events;
      end
    end
  end

  // ==========================================================================
  // Receive FIFO writer: appends the frame status byte after the last byte
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || datapath_reset_reg)
    begin
      pending_reg <= 1'b0;
      pending_byte_reg <= 8'h00;
      fifo_write_reg <= '0;
    end
    else if (pending_reg)
    begin
      fifo_write_reg <= '{valid: 1'b1, data: pending_byte_reg, last: 1'b1};
      pending_reg <= 1'b0;
    end
    else
    begin
      fifo_write_reg <= '{valid: rx_data_i.valid, data: rx_data_i.data, last: 1'b0};
      if (rx_frame_i.done)
      begin
        pending_reg <= 1'b1;
        pending_byte_reg <= passed_events;
      end
    end
  end

  // ==========================================================================
  // Path stop state machines
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || datapath_reset_reg)
    begin
      tx_state_reg <= port_regs_pkg::PATH_STOP;
    end
    else
    begin
      case (tx_state_reg)
        port_regs_pkg::PATH_RUN:
          if (!port_control_reg[port_regs_pkg::BIT_TX_ENABLE])
            tx_state_reg <= port_regs_pkg::PATH_DRAIN;
        port_regs_pkg::PATH_DRAIN:
          if (port_control_reg[port_regs_pkg::BIT_TX_ENABLE])
            tx_state_reg <= port_regs_pkg::PATH_RUN;
          else if (!tx_busy_i)
            tx_state_reg <= port_regs_pkg::PATH_STOP;
        default:
          if (port_control_reg[port_regs_pkg::BIT_TX_ENABLE])
            tx_state_reg <= port_regs_pkg::PATH_RUN;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || datapath_reset_reg)
    begin
      rx_state_reg <= port_regs_pkg::PATH_STOP;
    end
    else
    begin
      case (rx_state_reg)
        port_regs_pkg::PATH_RUN:
          if (!port_control_reg[port_regs_pkg::BIT_RX_ENABLE])
            rx_state_reg <= port_regs_pkg::PATH_DRAIN;
        port_regs_pkg::PATH_DRAIN:
          if (port_control_reg[port_regs_pkg::BIT_RX_ENABLE])
            rx_state_reg <= port_regs_pkg::PATH_RUN;
          else if (!rx_busy_i)
            rx_state_reg <= port_regs_pkg::PATH_STOP;
        default:
          if (port_control_reg[port_regs_pkg::BIT_RX_ENABLE])
            rx_state_reg <= port_regs_pkg::PATH_RUN;
      endcase
    end
  end

  // Stopped flag: set when each draining or stopped path is done; read clears
  logic tx_disabled;
  logic rx_disabled;
  logic stop_event;
  logic stop_arm_reg;
  assign tx_disabled = tx_state_reg != port_regs_pkg::PATH_RUN;
  assign rx_disabled = rx_state_reg != port_regs_pkg::PATH_RUN;
  assign stop_event = (tx_disabled || rx_disabled)
    && (!tx_disabled || tx_state_reg == port_regs_pkg::PATH_STOP)
    && (!rx_disabled || rx_state_reg == port_regs_pkg::PATH_STOP)
    && !(tx_state_reg == port_regs_pkg::PATH_STOP && rx_state_reg == port_regs_pkg::PATH_STOP
         && !port_control_reg[port_regs_pkg::BIT_TX_ENABLE]
         && !port_control_reg[port_regs_pkg::BIT_RX_ENABLE]
         && !stop_arm_reg);
  // Arms when any path has run, so the idle state after reset is not a stop
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || datapath_reset_reg)
    begin
      stop_arm_reg <= 1'b0;
    end
    else if (!tx_disabled || !rx_disabled)
    begin
      stop_arm_reg <= 1'b1;
    end
    else if (stop_event)
    begin
      stop_arm_reg <= 1'b0;
    end
  end

  // Sticky stopped flag; a stop in the cycle of a clearing read still sets it
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || soft_reset)
    begin
      stopped_reg <= 1'b0;
    end
    else if (stop_event && stop_arm_reg)
    begin
      stopped_reg <= 1'b1; // set wins over read
    end
    else if (rd && paddr_i == port_regs_pkg::OFF_INTERRUPT_STATUS)
    begin
      stopped_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data and response
  logic [7:0] read_byte;
  logic addr_ok;
  always_comb
  begin
    read_byte = 8'h00;
    addr_ok = 1'b1;
    if (paddr_i == port_regs_pkg::OFF_RX_EVENT_STATUS)
      read_byte = rx_event_status_reg;
    else if (paddr_i == port_regs_pkg::OFF_PORT_CONTROL)
      read_byte = port_control_reg;
    else if (paddr_i == port_regs_pkg::OFF_DEVICE_IDENTIFIER)
      read_byte = IS_PORT_ZERO ? port_regs_pkg::DEVICE_IDENTIFIER_VALUE : 8'h00;
    else if (paddr_i == port_regs_pkg::OFF_REVISION_IDENTIFIER)
      read_byte = IS_PORT_ZERO ? {port_regs_pkg::MAIN_REVISION_VALUE,
                                  port_regs_pkg::SUB_REVISION_VALUE} : 8'h00;
    else if (paddr_i == port_regs_pkg::OFF_RX_FILTERING_MODE)
      read_byte = rx_filtering_mode_reg;
    else if (paddr_i == port_regs_pkg::OFF_INTERRUPT_STATUS)
      read_byte = {1'b0, stopped_reg, 6'h00};
    else
      addr_ok = 1'b0;
  end

  // Zero-wait answer: pready stands high, data comes combinationally
  always_comb
  begin
    pready_o = 1'b1;
    prdata_o = {24'h000000, read_byte};
    pslverr_o = access && !addr_ok;
  end

  // ==========================================================================
  // Outputs
  always_comb
  begin
    tx_enable_o = tx_state_reg != port_regs_pkg::PATH_STOP;
    rx_enable_o = rx_state_reg != port_regs_pkg::PATH_STOP;
    tx_restart_o = port_control_reg[port_regs_pkg::BIT_TX_RESTART];
    datapath_reset_o = datapath_reset_reg;
    statistics_clear_o = stats_busy_reg;
    rx_filtering_mode_o = rx_filtering_mode_reg;
    rx_event_status_o = rx_event_status_reg;
    stopped_o = stopped_reg;
    fifo_write_o = fifo_write_reg;
  end
endmodule : port_regs
`default_nettype wire

//--- test/port_regs_checker.sv
// Checker for the per-port status and control registers.
// Assumes it is bound to port_regs; one clock, synchronous active-low reset.
`default_nettype none
module port_regs_checker #(
  parameter bit IS_PORT_ZERO = 1'b1
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire port_regs_pkg::rx_frame_s rx_frame_i,
  input wire logic rx_busy_i,
  input wire port_regs_pkg::fifo_byte_s fifo_write_o,
  input wire logic tx_enable_o,
  input wire logic rx_enable_o,
  input wire logic tx_restart_o,
  input wire logic datapath_reset_o,
  input wire logic statistics_clear_o,
  input wire logic [7:0] rx_filtering_mode_o,
  input wire logic [7:0] rx_event_status_o,
  input wire logic stopped_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Helpers
  logic [7:0] clr_cnt;
  wire logic acc = psel_i && penable_i;
  wire logic pc_wr = acc && pwrite_i && pstrb_i[0] && paddr_i == 8'h04;
  wire logic st_rd = acc && !pwrite_i && paddr_i == 8'h00;
  wire logic fdone = rx_frame_i.done && rx_filtering_mode_o == 8'hBF;
  // Counts cycles of an active statistics clear
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i || !statistics_clear_o) clr_cnt <= 8'h00;
    else clr_cnt <= clr_cnt + 8'h01;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================================
  // Properties
  AST_RD_CLEAR: assert property (st_rd && !rx_frame_i.done |=> rx_event_status_o == 8'h00)
    else $error("status kept after read");
  AST_RSVD: assert property (rx_event_status_o[6] == 1'b0)
    else $error("reserved status bit set");
  AST_FILTER: assert property ($rose(rx_event_status_o[7]) |-> $past(rx_filtering_mode_o[7]))
    else $error("status set while filtered");
  AST_PAUSE: assert property (fdone && rx_frame_i.pause_frame |=> rx_event_status_o[7])
    else $error("pause bit missing");
  AST_LONG: assert property (fdone && rx_frame_i.oversize |=> rx_event_status_o[4])
    else $error("oversize bit missing");
  AST_SHORT: assert property (fdone && rx_frame_i.length < 16'h0040 |=> rx_event_status_o[3])
    else $error("undersize bit missing");
  AST_ALIGN: assert property (fdone && rx_frame_i.fcs_error && rx_frame_i.framing_error
    |=> rx_event_status_o[2])
    else $error("alignment bit missing");
  AST_FCS: assert property (fdone && rx_frame_i.fcs_error && !rx_frame_i.framing_error
    |=> rx_event_status_o[1])
    else $error("check sequence bit missing");
  AST_APPEND: assert property (rx_frame_i.done |=> ##1 fifo_write_o.valid && fifo_write_o.last)
    else $error("status byte not appended");
  AST_RESTART: assert property (pc_wr && pwdata_i[5] |=> tx_restart_o ##1 !tx_restart_o)
    else $error("restart pulse wrong");
  AST_RXSTOP: assert property (pc_wr && !pwdata_i[3] && !rx_busy_i |-> ##[1:3] !rx_enable_o)
    else $error("receive path not stopped");
  AST_DATAPATH_RESET: assert property (pc_wr && pwdata_i[2] |-> ##[1:2] datapath_reset_o)
    else $error("datapath reset missing");
  AST_REGRST: assert property (pc_wr && pwdata_i[1] |-> ##[1:3] rx_filtering_mode_o == 8'h00)
    else $error("register reset missing");
  AST_STATS: assert property ($fell(statistics_clear_o) |-> clr_cnt == 8'h64)
    else $error("statistics clear length wrong");
  AST_DEVID: assert property (acc && !pwrite_i && paddr_i == 8'h08 |->
    prdata_o[7:0] == (IS_PORT_ZERO ? port_regs_pkg::DEVICE_IDENTIFIER_VALUE : 8'h00))
    else $error("device identifier wrong");
  AST_STOPPED: assert property ($rose(stopped_o) |-> !(tx_enable_o && rx_enable_o))
    else $error("stopped while both paths run");
endmodule // port_regs_checker
bind port_regs port_regs_checker #(.IS_PORT_ZERO(IS_PORT_ZERO)) chk (.*);
`default_nettype wire

//--- test/rx_source.sv
// Receive datapath model that feeds frames into the port register block.
// Assumes the bench pulses start_i with the frame report held on frame_i.
`default_nettype none
module rx_source (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire port_regs_pkg::rx_frame_s frame_i,
  output port_regs_pkg::rx_frame_s frame_o,
  output port_regs_pkg::fifo_byte_s data_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Frame sequencer
  logic [2:0] left;
  // Streams four bytes, then pulses done; idle byte lane keeps toggling
  always_ff @(posedge clock_i)
  begin
    frame_o.done <= 1'b0;
    data_o.valid <= 1'b0;
    data_o.last <= 1'b0;
    data_o.data <= ~data_o.data;
    if (!reset_n_i)
    begin
      busy_o <= 1'b0;
      left <= 3'h0;
      frame_o <= '0;
      data_o <= '0;
    end
    else if (start_i)
    begin
      busy_o <= 1'b1;
      left <= 3'h4;
      frame_o <= frame_i;
    end
    else if (left != 3'h0)
    begin
      data_o <= {1'b1, 8'h50 + {5'h0, left}, left == 3'h1};
      left <= left - 3'h1;
    end
    else if (busy_o)
    begin
      frame_o.done <= 1'b1;
      busy_o <= 1'b0;
    end
  end
endmodule // rx_source
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the port register block.
// Assumes an APB master here and the receive model in rx_source.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  localparam logic [7:0] A_ST = 8'h00;
  localparam logic [7:0] A_PC = 8'h04;
  localparam logic [7:0] A_FM = 8'h10;
  logic clock_i, reset_n_i, psel_i, penable_i, pwrite_i, symbol_mode_i, tx_busy_i, start;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic [3:0] pstrb_i;
  logic pready_o, pslverr_o, rx_busy_i, tx_enable_o, rx_enable_o, tx_restart_o, err;
  logic datapath_reset_o, statistics_clear_o, stopped_o;
  logic [7:0] rx_filtering_mode_o, rx_event_status_o;
  port_regs_pkg::rx_frame_s rx_frame_i, frm;
  port_regs_pkg::fifo_byte_s rx_data_i, fifo_write_o;
  int error_cnt = 0;
  int checks_done = 0;
  port_regs dut (.*);
  rx_source src (.clock_i, .reset_n_i, .start_i(start), .frame_i(frm), .frame_o(rx_frame_i),
    .data_o(rx_data_i), .busy_o(rx_busy_i));
  // Clock, 5 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    // Waits for ready; only the watchdog ends a hung transfer
    do
    begin
      @(posedge clock_i);
    end
    while (pready_o !== 1'b1);
    rdata = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, rdata);
  endtask
  // Sends one frame under a filter setting and checks status and FIFO byte
  task automatic frame(input logic [7:0] fm, input logic [2:0] pmo, input logic [15:0] len,
    input logic [2:0] cfv, input logic [7:0] exp);
    int n;
    n = 0;
    apb(1'b1, A_FM, {24'h0, fm});
    frm <= {1'h0, pmo, len, cfv};
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    do @(posedge clock_i); while (rx_frame_i.done !== 1'b1 && n++ < 32);
    n = 0;
    do @(posedge clock_i); while (!(fifo_write_o.valid & fifo_write_o.last) && n++ < 4);
    chk("fifo byte", {24'h1, exp}, {23'h0, fifo_write_o.valid & fifo_write_o.last,
      fifo_write_o.data});
    chk("status out", {24'h0, exp}, {24'h0, rx_event_status_o});
    rd(A_ST, {24'h0, exp});
    rd(A_ST, 32'h0);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    int n;
    {reset_n_i, psel_i, penable_i, pwrite_i, symbol_mode_i, tx_busy_i, start} = '0;
    {paddr_i, pwdata_i, frm} = '0;
    pstrb_i = 4'hF;
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(A_ST, 32'h0);
    rd(A_PC, 32'h0);
    rd(8'h08, {24'h0, port_regs_pkg::DEVICE_IDENTIFIER_VALUE});
    rd(8'h0C, {24'h0, port_regs_pkg::MAIN_REVISION_VALUE, port_regs_pkg::SUB_REVISION_VALUE});
    rd(8'h18, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    apb(1'b1, A_PC, 32'h18);
    frame(8'hBF, 3'h0, 16'h0064, 3'h4, 8'h02);
    frame(8'hBF, 3'h0, 16'h000A, 3'h6, 8'h0C);
    frame(8'hBF, 3'h7, 16'h0064, 3'h1, 8'hB1);
    frame(8'h02, 3'h0, 16'h000A, 3'h4, 8'h00);
    frame(8'h7F, 3'h4, 16'h0064, 3'h0, 8'h00);
    // Write without lane 0 strobe is ignored
    pstrb_i <= 4'h0;
    apb(1'b1, A_FM, 32'h0);
    pstrb_i <= 4'hF;
    rd(A_FM, 32'h3F);
    // Restart pulse lasts one cycle
    apb(1'b1, A_PC, 32'h38);
    @(posedge clock_i);
    chk("restart", 32'h1, {31'h0, tx_restart_o});
    @(posedge clock_i);
    chk("restart", 32'h0, {31'h0, tx_restart_o});
    // Transmit drains its frame, receive stops at once
    tx_busy_i <= 1'b1;
    apb(1'b1, A_PC, 32'h0);
    repeat (4) @(posedge clock_i);
    chk("paths", 32'h2, {30'h0, tx_enable_o, rx_enable_o});
    chk("stopped", 32'h0, {31'h0, stopped_o});
    tx_busy_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk("paths", 32'h0, {30'h0, tx_enable_o, rx_enable_o});
    rd(8'h14, 32'h40);
    apb(1'b1, A_PC, 32'h04);
    repeat (2) @(posedge clock_i);
    chk("port reset", 32'h1, {31'h0, datapath_reset_o});
    @(posedge clock_i);
    chk("port reset", 32'h0, {31'h0, datapath_reset_o});
    // Register reset and statistics clear are written apart
    apb(1'b1, A_PC, 32'h02);
    repeat (2) @(posedge clock_i);
    rd(A_FM, 32'h0);
    apb(1'b1, A_PC, 32'h01);
    n = 0;
    while (statistics_clear_o !== 1'b1 && n++ < 4) @(posedge clock_i);
    n = 0;
    // No register access while the clear runs
    while (statistics_clear_o === 1'b1 && n < 200)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("clear cycles", 32'd100, 32'(n));
    rd(A_PC, 32'h0);
    report_and_stop();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
